/* File: logic/sfc_port.sv */
`timescale 1ns/10ps
`default_nettype none
module sfc_port (
   input  wire logic       clock_in,      // System clock, 40 MHz
   input  wire logic       rstn_in,       // Async reset, active low
   input  wire logic [7:0] sfr_addr_in,   // Register address
   input  wire logic       sfr_wr_in,     // Write strobe
   input  wire logic       sfr_rd_in,     // Read strobe
   input  wire logic [7:0] sfr_wdata_in,  // Write data
   output logic      [7:0] sfr_rdata_out, // Read data, next cycle
   input  wire logic       irq_en_in,     // Port interrupts enabled
   output logic            irq_req_out,   // Interrupt request level
   input  wire logic       sck_in,        // Serial clock pin in
   output logic            sck_out,       // Serial clock pin out
   output logic            sck_oe_out,    // Serial clock drive
   input  wire logic       mosi_in,       // Master-out pin in
   output logic            mosi_out,      // Master-out pin out
   output logic            mosi_oe_out,   // Master-out drive
   input  wire logic       miso_in,       // Master-in pin in
   output logic            miso_out,      // Master-in pin out
   output logic            miso_oe_out,   // Master-in drive
   input  wire logic       slave_select_n_in,     // Select pin in
   output logic            slave_select_n_out,    // Select pin out
   output logic            slave_select_n_oe_out  // Select pin drive
);

   typedef struct packed {
      sfc_pkg::sfc_mstate_e mstate;
      logic [8:0]           hcnt;
      logic [2:0]           bitn;
      logic [7:0]           mshift;
      logic                 sck;
      logic                 mosi;
      logic                 xfer_done_flag;
      logic                 write_collision_flag;
      logic                 mode_fault_flag;
      logic                 rx_overrun_flag;
      logic [1:0]           select_mode_field;
      logic                 port_enable;
      logic                 master_enable;
      logic                 clock_phase_sel;
      logic                 clock_polarity_sel;
      logic [7:0]           clock_rate_reg;
      logic [7:0]           tx_buf;
      logic                 tx_full;
      logic [7:0]           slv_tx;
      logic                 slv_loaded;
      logic [7:0]           rx_buf;
      logic                 rx_full;
      logic                 done_seen;
      logic [7:0]           rdata;
   } sfc_port_s;

   sfc_port_s  s;
   sfc_port_s  next_s;

   logic       link_clk;
   logic       link_rstn;
   logic       four_wire;
   logic       link_miso;
   logic       link_busy;
   logic       link_done;
   logic [7:0] link_rx;
   logic [3:0] synced;
   logic       sel_sync;
   logic       miso_sync;
   logic       done_sync;
   logic       busy_sync;
   logic       master_active;
   logic       slave_active;
   logic       slave_selected;
   logic       half_done;
   logic [8:0] half_len;
   logic [7:0] m_byte;
   logic       m_byte_done;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction : hit

   sfc_sync #(
      .W(4)
   ) u_sync (
      .clock_in (clock_in),
      .rstn_in  (rstn_in),
      .d_in     ({~slave_select_n_in, miso_in, link_done, link_busy}),
      .q_out    (synced)
   );

   // Select synced inverted, so reset reads deselected
   assign sel_sync  = ~synced[3];
   assign miso_sync = synced[2];
   assign done_sync = synced[1];
   assign busy_sync = synced[0];

   assign four_wire      = (s.select_mode_field == sfc_pkg::SELMD_MULTI);
   assign master_active  = s.port_enable & s.master_enable;
   assign slave_active   = s.port_enable & ~s.master_enable;
   assign slave_selected = slave_active & (~four_wire | ~sel_sync);

   assign link_clk  = sck_in ^ s.clock_polarity_sel ^ s.clock_phase_sel;
   assign link_rstn = rstn_in & slave_active & ~(four_wire & slave_select_n_in);

   sfc_slave_link u_link (
      .link_clk_in   (link_clk),
      .frame_rstn_in (link_rstn),
      .rstn_in       (rstn_in),
      .mosi_in       (mosi_in),
      .tx_byte_in    (s.slv_tx),
      .miso_out      (link_miso),
      .busy_out      (link_busy),
      .done_tgl_out  (link_done),
      .rx_byte_out   (link_rx)
   );

   always_comb begin
      half_len = {1'b0, s.clock_rate_reg} + 9'h001;
      if (half_len < sfc_pkg::MIN_HALF_CYCLES) begin
         half_len = sfc_pkg::MIN_HALF_CYCLES;
      end
   end

   assign half_done = (s.hcnt == half_len - 9'h001);

   always_comb begin
      next_s      = s;
      m_byte      = s.mshift;
      m_byte_done = 1'b0;

      if (sfr_wr_in) begin
         if (hit(sfr_addr_in, sfc_pkg::ADDR_CTRL)) begin
            next_s.xfer_done_flag       = sfr_wdata_in[sfc_pkg::CTRL_XFER_DONE];
            next_s.write_collision_flag = sfr_wdata_in[sfc_pkg::CTRL_COLL];
            next_s.mode_fault_flag      = sfr_wdata_in[sfc_pkg::CTRL_FAULT];
            next_s.rx_overrun_flag      = sfr_wdata_in[sfc_pkg::CTRL_OVERRUN];
            next_s.select_mode_field    =
               sfr_wdata_in[sfc_pkg::CTRL_SELMD_HI:sfc_pkg::CTRL_SELMD_LO];
            next_s.port_enable          = sfr_wdata_in[sfc_pkg::CTRL_PORT_EN];
         end
         if (hit(sfr_addr_in, sfc_pkg::ADDR_CFG)) begin
            next_s.master_enable      = sfr_wdata_in[sfc_pkg::CFG_MASTER];
            next_s.clock_phase_sel    = sfr_wdata_in[sfc_pkg::CFG_PHA];
            next_s.clock_polarity_sel = sfr_wdata_in[sfc_pkg::CFG_POL];
         end
         if (hit(sfr_addr_in, sfc_pkg::ADDR_CKR)) begin
            next_s.clock_rate_reg = sfr_wdata_in;
         end
         if (hit(sfr_addr_in, sfc_pkg::ADDR_DATA)) begin
            if (!s.tx_full) begin
               next_s.tx_buf  = sfr_wdata_in;
               next_s.tx_full = 1'b1;
            end
         end
      end

      // Register reads
      if (sfr_rd_in) begin
         next_s.rdata = sfc_pkg::BYTE_RESET;
         if (hit(sfr_addr_in, sfc_pkg::ADDR_CTRL)) begin
            next_s.rdata = {s.xfer_done_flag, s.write_collision_flag, s.mode_fault_flag,
                            s.rx_overrun_flag, s.select_mode_field, ~s.tx_full,
                            s.port_enable};
         end
         if (hit(sfr_addr_in, sfc_pkg::ADDR_CFG)) begin
            next_s.rdata = {(s.mstate != sfc_pkg::M_IDLE) | (slave_active & busy_sync),
                            s.master_enable, s.clock_phase_sel, s.clock_polarity_sel,
                            ~sel_sync, slave_select_n_in,
                            s.master_enable | ~s.slv_loaded,
                            s.master_enable | ~s.rx_full};
         end
         if (hit(sfr_addr_in, sfc_pkg::ADDR_CKR)) begin
            next_s.rdata = s.clock_rate_reg;
         end
         if (hit(sfr_addr_in, sfc_pkg::ADDR_DATA)) begin
            next_s.rdata   = s.rx_buf;
            next_s.rx_full = 1'b0;
         end
      end

      // Master engine
      case (s.mstate)
         sfc_pkg::M_IDLE: begin
            next_s.sck  = s.clock_polarity_sel;
            next_s.hcnt = 9'h000;
            next_s.bitn = 3'h0;
            if (master_active && s.tx_full) begin
               next_s.mshift  = s.tx_buf;
               next_s.tx_full = 1'b0;
               next_s.mstate  = sfc_pkg::M_LEAD;
               if (!s.clock_phase_sel) begin
                  next_s.mosi = s.tx_buf[7];
               end
            end
         end
         sfc_pkg::M_LEAD: begin
            next_s.hcnt = s.hcnt + 9'h001;
            if (half_done) begin
               next_s.hcnt   = 9'h000;
               next_s.sck    = ~s.clock_polarity_sel;
               next_s.mstate = sfc_pkg::M_TRAIL;
               if (!s.clock_phase_sel) begin
                  next_s.mshift = {s.mshift[6:0], miso_sync};
               end else begin
                  next_s.mosi = s.mshift[7];
               end
            end
         end
         sfc_pkg::M_TRAIL: begin
            next_s.hcnt = s.hcnt + 9'h001;
            if (half_done) begin
               next_s.hcnt   = 9'h000;
               next_s.sck    = s.clock_polarity_sel;
               next_s.bitn   = s.bitn + 3'h1;
               next_s.mstate = sfc_pkg::M_LEAD;
               if (s.clock_phase_sel) begin
                  next_s.mshift = {s.mshift[6:0], miso_sync};
                  m_byte        = {s.mshift[6:0], miso_sync};
               end else begin
                  next_s.mosi = s.mshift[7];
               end
               if (s.bitn == 3'h7) begin
                  m_byte_done   = 1'b1;
                  next_s.mstate = sfc_pkg::M_IDLE;
               end
            end
         end
         default: begin
            next_s.mstate = sfc_pkg::M_IDLE;
         end
      endcase

      if (m_byte_done) begin
         next_s.rx_buf  = m_byte;
         next_s.rx_full = 1'b1;
      end

      // Slave transmit byte handed to the link between bytes
      if (slave_active && s.tx_full && !s.slv_loaded) begin
         next_s.slv_tx     = s.tx_buf;
         next_s.slv_loaded = 1'b1;
         next_s.tx_full    = 1'b0;
      end

      // Slave byte completion
      next_s.done_seen = done_sync;
      if (slave_active && (done_sync != s.done_seen)) begin
         next_s.slv_loaded = 1'b0;
         if (s.rx_full) begin
            next_s.rx_overrun_flag = 1'b1;
         end else begin
            next_s.rx_buf  = link_rx;
            next_s.rx_full = 1'b1;
         end
      end

      if (m_byte_done || (slave_active && (done_sync != s.done_seen))) begin
         next_s.xfer_done_flag = 1'b1;
      end

      if (sfr_wr_in && hit(sfr_addr_in, sfc_pkg::ADDR_DATA) && s.tx_full) begin
         next_s.write_collision_flag = 1'b1;
      end

      if (master_active && four_wire && !sel_sync) begin
         next_s.mode_fault_flag = 1'b1;
         next_s.master_enable   = 1'b0;
         next_s.port_enable     = 1'b0;
         next_s.mstate          = sfc_pkg::M_IDLE;
         next_s.sck             = s.clock_polarity_sel;
      end else if (!master_active && (s.mstate != sfc_pkg::M_IDLE)) begin
         next_s.mstate = sfc_pkg::M_IDLE;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s                   <= '0;
         s.mstate            <= sfc_pkg::M_IDLE;
         s.select_mode_field <= sfc_pkg::SELMD_RESET;
         s.clock_rate_reg    <= sfc_pkg::RATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign irq_req_out = irq_en_in & (s.xfer_done_flag | s.write_collision_flag |
                                     s.mode_fault_flag | s.rx_overrun_flag);

   assign sfr_rdata_out         = s.rdata;
   assign sck_out               = s.sck;
   assign sck_oe_out            = master_active;
   assign mosi_out              = s.mosi;
   assign mosi_oe_out           = master_active;
   assign miso_out              = link_miso;
   assign miso_oe_out           = slave_selected;
   assign slave_select_n_out    = s.select_mode_field[0];
   assign slave_select_n_oe_out = s.port_enable & s.select_mode_field[1];

endmodule : sfc_port
`default_nettype wire

/* File: shared/sfc_pkg.sv */
`default_nettype none
package sfc_pkg;

   // Register addresses on the special function bus
   localparam logic [7:0] ADDR_CTRL = 8'hF8;
   localparam logic [7:0] ADDR_CFG  = 8'hA1;
   localparam logic [7:0] ADDR_CKR  = 8'hA2;
   localparam logic [7:0] ADDR_DATA = 8'hA3;

   // Control register fields
   localparam int CTRL_XFER_DONE = 7;
   localparam int CTRL_COLL      = 6;
   localparam int CTRL_FAULT     = 5;
   localparam int CTRL_OVERRUN   = 4;
   localparam int CTRL_SELMD_HI  = 3;
   localparam int CTRL_SELMD_LO  = 2;
   localparam int CTRL_TXBMT     = 1;
   localparam int CTRL_PORT_EN   = 0;

   // Configuration register fields
   localparam int CFG_BUSY    = 7;
   localparam int CFG_MASTER  = 6;
   localparam int CFG_PHA     = 5;
   localparam int CFG_POL     = 4;
   localparam int CFG_SELECT  = 3;
   localparam int CFG_PINRAW  = 2;
   localparam int CFG_SHEMPTY = 1;
   localparam int CFG_RXEMPTY = 0;

   // Select mode encodings and reset values
   localparam logic [1:0] SELMD_THREE_WIRE = 2'h0;
   localparam logic [1:0] SELMD_MULTI      = 2'h1;
   localparam logic [1:0] SELMD_RESET      = 2'h1;
   localparam logic [7:0] RATE_RESET       = 8'h00;
   localparam logic [7:0] BYTE_RESET       = 8'h00;

   // Master bit-rate ceiling
   localparam int SYS_CLK_KHZ       = 40000;
   localparam int MASTER_MAX_KHZ    = 12500;
   localparam int MASTER_BIT_CYCLES = (SYS_CLK_KHZ + MASTER_MAX_KHZ - 1) / MASTER_MAX_KHZ;
   localparam logic [8:0] MIN_HALF_CYCLES = 9'((MASTER_BIT_CYCLES + 1) / 2);

   typedef enum logic [1:0] {
      M_IDLE,
      M_LEAD,
      M_TRAIL
   } sfc_mstate_e;

endpackage : sfc_pkg
`default_nettype wire

/* File: logic/sfc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module sfc_sync #(
   parameter int W = 4
) (
   input  wire logic         clock_in,  // System clock
   input  wire logic         rstn_in,   // Async reset, active low
   input  wire logic [W-1:0] d_in,      // Foreign-domain levels
   output logic      [W-1:0] q_out      // Synchronised levels
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sfc_sync_s;

   sfc_sync_s s;
   sfc_sync_s next_s;

   always_comb begin
      next_s.stage1 = d_in;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q_out = s.stage2;

endmodule : sfc_sync
`default_nettype wire

/* File: logic/sfc_slave_link.sv */
`timescale 1ns/10ps
`default_nettype none
module sfc_slave_link (
   input  wire logic       link_clk_in,   // Serial clock, sample edge rising
   input  wire logic       frame_rstn_in, // Clears bit counter, active low
   input  wire logic       rstn_in,       // Device reset, active low
   input  wire logic       mosi_in,       // Serial data in
   input  wire logic [7:0] tx_byte_in,    // Byte to shift out, stable
   output logic            miso_out,      // Serial data out
   output logic            busy_out,      // Bits pending in frame
   output logic            done_tgl_out,  // Toggles per byte
   output logic [7:0]      rx_byte_out    // Last complete byte
);

   typedef struct packed {
      logic [2:0] cnt;
      logic [6:0] shift;
   } sfc_frame_s;

   typedef struct packed {
      logic [7:0] rx_byte;
      logic       done_tgl;
   } sfc_result_s;

   sfc_frame_s  f;
   sfc_frame_s  next_f;
   sfc_result_s r;
   sfc_result_s next_r;

   always_comb begin
      next_f = f;
      next_r = r;
      next_f.shift = {f.shift[5:0], mosi_in};
      next_f.cnt   = f.cnt + 3'h1;
      if (f.cnt == 3'h7) begin
         next_r.rx_byte  = {f.shift, mosi_in};
         next_r.done_tgl = ~r.done_tgl;
      end
   end

   // Counter survives only while selected; result survives frames
   always_ff @(posedge link_clk_in or negedge frame_rstn_in) begin
      if (!frame_rstn_in) begin
         f <= '0;
      end else begin
         f <= next_f;
      end
   end

   always_ff @(posedge link_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // MSB first, next bit follows each sample edge
   assign miso_out     = tx_byte_in[~f.cnt];
   assign busy_out     = (f.cnt != 3'h0);
   assign done_tgl_out = r.done_tgl;
   assign rx_byte_out  = r.rx_byte;

endmodule : sfc_slave_link
`default_nettype wire

/* File: tb/sfc_port_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module sfc_port_properties (
   input wire logic       clock_in,          // System clock
   input wire logic       rstn_in,           // Reset, active low
   input wire logic [7:0] sfr_addr_in,       // Register address
   input wire logic       sfr_wr_in,         // Write strobe
   input wire logic       sfr_rd_in,         // Read strobe
   input wire logic [7:0] sfr_wdata_in,      // Write data
   input wire logic [7:0] sfr_rdata_out,     // Read data
   input wire logic       irq_en_in,         // Interrupt enable
   input wire logic       irq_req_out,       // Interrupt request
   input wire logic       sck_out,           // Serial clock out
   input wire logic       sck_oe_out,        // Serial clock drive
   input wire logic       miso_oe_out,       // Master-in drive
   input wire logic       slave_select_n_in  // Select pin
);
   logic       pol_q;
   logic [1:0] mode_q;

   // Shadow of written polarity and select mode
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pol_q  <= 1'b0;
         mode_q <= sfc_pkg::SELMD_RESET;
      end else if (sfr_wr_in && sfr_addr_in == sfc_pkg::ADDR_CFG) begin
         pol_q <= sfr_wdata_in[sfc_pkg::CFG_POL];
      end else if (sfr_wr_in && sfr_addr_in == sfc_pkg::ADDR_CTRL) begin
         mode_q <= sfr_wdata_in[3:2];
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   sequence s_stray_read;
      sfr_rd_in && sfr_addr_in != sfc_pkg::ADDR_CTRL && sfr_addr_in != sfc_pkg::ADDR_CFG
         && sfr_addr_in != sfc_pkg::ADDR_CKR && sfr_addr_in != sfc_pkg::ADDR_DATA;
   endsequence
   sequence s_fault_cause;
      sck_oe_out && mode_q == sfc_pkg::SELMD_MULTI && !slave_select_n_in;
   endsequence

   a_rdata_hold: assert property (!$past(sfr_rd_in) |-> $stable(sfr_rdata_out))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (s_stray_read |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_select_raw: assert property (sfr_rd_in && sfr_addr_in == sfc_pkg::ADDR_CFG
      |=> sfr_rdata_out[sfc_pkg::CFG_PINRAW] == $past(slave_select_n_in))
      else $error("select pin bit not the raw pin");
   a_irq_gated: assert property (irq_req_out |-> irq_en_in)
      else $error("interrupt while disabled");
   a_flag_sticky: assert property ($fell(irq_req_out) |-> !irq_en_in
      || $past(sfr_wr_in && sfr_addr_in == sfc_pkg::ADDR_CTRL))
      else $error("flag dropped without software");
   a_sck_half_min: assert property (sck_oe_out && $changed(sck_out)
      |=> !sck_oe_out || $stable(sck_out))
      else $error("serial clock half period below two cycles");
   a_role_excl: assert property (sck_oe_out |-> !miso_oe_out)
      else $error("master and slave drives together");
   a_idle_level: assert property ($rose(sck_oe_out) |-> sck_out == pol_q)
      else $error("idle clock level wrong");
   a_fault_release: assert property (s_fault_cause |-> ##[0:4] !sck_oe_out)
      else $error("master kept bus after select low");
endmodule : sfc_port_properties

bind sfc_port sfc_port_properties u_sfc_port_properties (.clock_in, .rstn_in, .sfr_addr_in,
   .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .irq_en_in, .irq_req_out, .sck_out,
   .sck_oe_out, .miso_oe_out, .slave_select_n_in);
`default_nettype wire

/* File: tb/sfc_spi_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module sfc_spi_partner (
   input  wire logic       base_clk_in,   // Link base clock
   input  wire logic       pha_in,        // Clock phase
   input  wire logic       pol_in,        // Clock polarity
   input  wire logic       role_slave_in, // Partner is slave
   input  wire logic       load_in,       // Preload slave byte
   input  wire logic       go_in,         // Start master frame
   input  wire logic       hold_sel_in,   // Hold select low
   input  wire logic [7:0] byte_in,       // Byte to send
   input  wire logic       sck_pin_in,    // Clock wire
   input  wire logic       mosi_pin_in,   // Master-out wire
   input  wire logic       miso_pin_in,   // Master-in wire
   output logic            sck_out,       // Clock drive
   output logic            mosi_out,      // Master-out drive
   output logic            miso_out,      // Master-in drive
   output logic            sel_n_out,     // Select drive
   output logic            frame_out,     // Frame running
   output logic [7:0]      got_out        // Byte received
);
   logic       sck_q = 1'b0;
   logic       first = 1'b0;
   logic [7:0] msh   = 8'h00;
   logic [7:0] ssh   = 8'h00;
   logic [7:0] mgot  = 8'h00;
   logic [7:0] sgot  = 8'h00;
   wire        act_x = sck_pin_in ^ pol_in ^ pha_in;

   initial frame_out = 1'b0;
   assign sck_out   = frame_out ? sck_q : pol_in;
   // Released lines show the inverse level
   assign mosi_out  = frame_out ? msh[7] : ~msh[7];
   assign miso_out  = role_slave_in ? ssh[7] : ~ssh[7];
   assign sel_n_out = !(frame_out || hold_sel_in);
   assign got_out   = role_slave_in ? sgot : mgot;

   always @(posedge act_x) if (role_slave_in) sgot <= {sgot[6:0], mosi_pin_in};
   always @(negedge act_x or posedge load_in) begin
      if (load_in) begin
         ssh   <= byte_in;
         first <= 1'b1;
      end else if (role_slave_in) begin
         if (!(pha_in && first)) ssh <= ssh << 1;
         first <= 1'b0;
      end
   end

   // bit period 256 ns, below a tenth
   always @(posedge go_in) begin
      msh       = byte_in;
      sck_q     = pol_in;
      frame_out = 1'b1;
      for (int i = 0; i < 8; i++) begin
         repeat (4) @(posedge base_clk_in);
         if (!pha_in) mgot = {mgot[6:0], miso_pin_in};
         else if (i > 0) msh = msh << 1;
         sck_q = ~pol_in;
         repeat (4) @(posedge base_clk_in);
         if (pha_in) mgot = {mgot[6:0], miso_pin_in};
         else msh = msh << 1;
         sck_q = pol_in;
      end
      repeat (4) @(posedge base_clk_in);
      frame_out = 1'b0;
   end
endmodule : sfc_spi_partner
`default_nettype wire

/* File: tb/sfc_port_test.sv */
`timescale 1ns/10ps
`default_nettype none
module sfc_port_test;
   logic       clock_in = 1'b0;
   logic       rstn_in  = 1'b0;
   logic       base_clk = 1'b0;
   logic [7:0] addr     = 8'h00;
   logic [7:0] wdata    = 8'h00;
   logic       wr       = 1'b0;
   logic       rd       = 1'b0;
   logic       irq_en   = 1'b0;
   logic       pha      = 1'b0;
   logic       pol      = 1'b0;
   logic       role_slv = 1'b1;
   logic       load     = 1'b0;
   logic       go       = 1'b0;
   logic       hold_sel = 1'b0;
   logic [7:0] pbyte    = 8'h00;
   logic [7:0] rdata, got, seen, tx, pb;
   logic       irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_o, sel_oe;
   logic       p_sck, p_mosi, p_miso, p_sel, p_frame;
   logic       sck_pin, mosi_pin, miso_pin, sel_pin;
   int         failures = 0;
   int         compares = 0;

   assign sck_pin  = sck_oe ? sck_o : p_sck;
   assign mosi_pin = mosi_oe ? mosi_o : p_mosi;
   assign miso_pin = miso_oe ? miso_o : p_miso;
   assign sel_pin  = sel_oe ? sel_o : p_sel;

   always #12.5 clock_in = ~clock_in;
   initial begin
      #7;
      forever #16 base_clk = ~base_clk;
   end

   sfc_port u_sfc_port (.clock_in(clock_in), .rstn_in(rstn_in), .sfr_addr_in(addr),
      .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
      .irq_en_in(irq_en), .irq_req_out(irq), .sck_in(sck_pin), .sck_out(sck_o),
      .sck_oe_out(sck_oe), .mosi_in(mosi_pin), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe),
      .miso_in(miso_pin), .miso_out(miso_o), .miso_oe_out(miso_oe),
      .slave_select_n_in(sel_pin), .slave_select_n_out(sel_o), .slave_select_n_oe_out(sel_oe));

   sfc_spi_partner u_sfc_spi_partner (.base_clk_in(base_clk), .pha_in(pha), .pol_in(pol),
      .role_slave_in(role_slv), .load_in(load), .go_in(go), .hold_sel_in(hold_sel),
      .byte_in(pbyte), .sck_pin_in(sck_pin), .mosi_pin_in(mosi_pin), .miso_pin_in(miso_pin),
      .sck_out(p_sck), .mosi_out(p_mosi), .miso_out(p_miso), .sel_n_out(p_sel),
      .frame_out(p_frame), .got_out(got));

   function automatic logic [7:0] cfg_val(input logic ms, input logic ph, input logic po);
      return {1'b0, ms, ph, po, 4'h0};
   endfunction : cfg_val

   task automatic give_verdict();
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen_v);
      compares++;
      if (seen_v !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen_v);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      @(negedge clock_in);
      v = rdata;
   endtask : rd_reg

   task automatic wait_irq();
      for (int n = 0; n < 400 && irq !== 1'b1; n++) @(negedge clock_in);
      chk("irq", 8'h01, {7'h00, irq});
   endtask : wait_irq

   task automatic slave_frame(input logic [7:0] b);
      @(posedge clock_in);
      pbyte <= b;
      @(posedge clock_in);
      go <= 1'b1;
      @(posedge clock_in);
      go <= 1'b0;
      for (int n = 0; n < 500 && p_frame !== 1'b0; n++) @(posedge clock_in);
      wait_irq();
   endtask : slave_frame

   initial begin
      #300000;
      failures++;
      give_verdict();
   end

   initial begin
      seen = 8'($urandom(32'h9739));
      repeat (8) @(posedge clock_in);
      rstn_in <= 1'b1;
      irq_en  <= 1'b1;
      rd_reg(sfc_pkg::ADDR_CTRL, seen); chk("ctrl reset", 8'h06, seen);
      rd_reg(sfc_pkg::ADDR_CFG, seen); chk("cfg reset", 8'h07, seen);
      rd_reg(sfc_pkg::ADDR_CKR, seen); chk("rate reset", 8'h00, seen);
      rd_reg(8'h55, seen); chk("unmapped", 8'h00, seen);
      wr_reg(sfc_pkg::ADDR_CFG, 8'h8F);
      rd_reg(sfc_pkg::ADDR_CFG, seen); chk("cfg read-only", 8'h07, seen);
      for (int m = 0; m < 4; m++) begin
         pha <= m[1];
         pol <= m[0];
         tx = 8'($urandom);
         pb = 8'($urandom);
         pbyte <= pb;
         wr_reg(sfc_pkg::ADDR_CTRL, 8'h00);
         wr_reg(sfc_pkg::ADDR_CFG, cfg_val(1'b1, m[1], m[0]));
         rd_reg(sfc_pkg::ADDR_CFG, seen); chk("cfg", cfg_val(1'b1, m[1], m[0]) | 8'h07, seen);
         wr_reg(sfc_pkg::ADDR_CKR, 8'(3 + $urandom % 5));
         @(posedge clock_in);
         load <= 1'b1;
         @(posedge clock_in);
         load <= 1'b0;
         wr_reg(sfc_pkg::ADDR_CTRL, 8'h01);
         @(posedge clock_in);
         addr  <= sfc_pkg::ADDR_DATA;
         wdata <= tx;
         wr    <= 1'b1;
         @(posedge clock_in);
         wdata <= ~tx;
         @(posedge clock_in);
         wr <= 1'b0;
         rd_reg(sfc_pkg::ADDR_CFG, seen); chk("busy", 8'h80, seen & 8'h80);
         // Collision already raised the request; wait out the byte
         repeat (140) @(posedge clock_in);
         wait_irq();
         rd_reg(sfc_pkg::ADDR_CTRL, seen); chk("master flags", 8'hC3, seen);
         rd_reg(sfc_pkg::ADDR_DATA, seen); chk("master rx", pb, seen);
         chk("partner rx", tx, got);
         chk("idle sck", {7'h00, pol}, {7'h00, sck_pin});
         wr_reg(sfc_pkg::ADDR_CTRL, 8'h01);
         @(negedge clock_in); chk("irq cleared", 8'h00, {7'h00, irq});
      end
      seen = 8'($urandom);
      pha      <= seen[1];
      pol      <= seen[0];
      role_slv <= 1'b0;
      tx = 8'($urandom);
      pb = 8'($urandom);
      wr_reg(sfc_pkg::ADDR_CTRL, 8'h00);
      wr_reg(sfc_pkg::ADDR_CFG, cfg_val(1'b0, seen[1], seen[0]));
      wr_reg(sfc_pkg::ADDR_CKR, 8'hFF);
      wr_reg(sfc_pkg::ADDR_CTRL, 8'h05);
      wr_reg(sfc_pkg::ADDR_DATA, tx);
      slave_frame(pb);
      rd_reg(sfc_pkg::ADDR_CTRL, seen); chk("slave flags", 8'h87, seen);
      chk("master got", tx, got);
      wr_reg(sfc_pkg::ADDR_CTRL, 8'h05);
      slave_frame(~pb);
      rd_reg(sfc_pkg::ADDR_CTRL, seen); chk("overrun flags", 8'h97, seen);
      rd_reg(sfc_pkg::ADDR_DATA, seen); chk("kept byte", pb, seen);
      wr_reg(sfc_pkg::ADDR_CTRL, 8'h05);
      wr_reg(sfc_pkg::ADDR_CFG, 8'h00);
      @(posedge clock_in);
      hold_sel <= 1'b1;
      repeat (4) @(posedge clock_in);
      rd_reg(sfc_pkg::ADDR_CFG, seen); chk("selected", 8'h08, seen & 8'hCC);
      wr_reg(sfc_pkg::ADDR_CFG, 8'h40);
      repeat (4) @(posedge clock_in);
      rd_reg(sfc_pkg::ADDR_CTRL, seen); chk("fault flags", 8'h26, seen);
      chk("fault irq", 8'h01, {7'h00, irq});
      rd_reg(sfc_pkg::ADDR_CFG, seen); chk("master off", 8'h00, seen & 8'h40);
      @(posedge clock_in);
      irq_en <= 1'b0;
      @(negedge clock_in); chk("irq masked", 8'h00, {7'h00, irq});
      hold_sel <= 1'b0;
      give_verdict();
   end
endmodule : sfc_port_test
`default_nettype wire
